/* pkg/sasq_consts.vh */
// register map, field positions, reset values and cycle counts of the scan sequencer
`ifndef SASQ_CONSTS_VH
`define SASQ_CONSTS_VH

// register byte offsets
`define SASQ_OFS_CTL        8'h00
`define SASQ_OFS_TRG        8'h04
`define SASQ_OFS_INTF       8'h08
`define SASQ_OFS_INTE       8'h0C
`define SASQ_OFS_RES0       8'h20
`define SASQ_OFS_RES7       8'h3C

// control register bit positions
`define SASQ_CTL_EN         0
`define SASQ_CTL_SWST       1
`define SASQ_CTL_TRIGGER_ACCEPT_ENABLE      4
`define SASQ_CTL_BUSY       10
`define SASQ_CTL_IDX_LSB    12

// trigger/input select register field positions
`define SASQ_TRG_SMP_LSB    0
`define SASQ_TRG_SRC_LSB    4
`define SASQ_TRG_REP        6
`define SASQ_TRG_ALIGN      7
`define SASQ_TRG_FIRST_LSB  8
`define SASQ_TRG_LAST_LSB   11

// reset values
`define SASQ_SMP_RST        3'h5

// trigger source codes
`define SASQ_SRC_SW         2'h0
`define SASQ_SRC_TMR        2'h1
`define SASQ_SRC_EXT        2'h3

// timing counts in shared clock cycles
`define SASQ_SMP_BASE       5'h04
`define SASQ_CONV_CYC       5'h0B
`define SASQ_STOP_HOLD      2'h2

// bus responses
`define SASQ_RESP_OKAY      2'h0
`define SASQ_RESP_SLVERR    2'h2

`endif

/* core/sasq_conv_timer.v */
// sampling and conversion phase timer for one analog input
`include "sasq_consts.vh"
module sasq_conv_timer (
   // clock and reset
   input  wire       clk,
   input  wire       nrst,
   // control
   input  wire       start,
   input  wire [2:0] smp_code,
   // phase outputs
   output wire       sampling,
   output wire       converting,
   output wire       done
);

   reg        active_reg;
   reg  [4:0] cnt_reg;
   wire [4:0] smp_len;
   wire [4:0] last_cnt;

   assign smp_len    = {2'b00, smp_code} + `SASQ_SMP_BASE;
   assign last_cnt   = smp_len + `SASQ_CONV_CYC - 5'h01;
   assign done       = active_reg & (cnt_reg == last_cnt);
   assign sampling   = active_reg & (cnt_reg < smp_len);
   assign converting = active_reg & ~sampling;

   // start wins over done so back-to-back inputs have no gap cycle
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         active_reg <= 1'b0;
         cnt_reg    <= 5'h00;
      end
      else if (start)
      begin
         active_reg <= 1'b1;
         cnt_reg    <= 5'h00;
      end
      else if (done)
         active_reg <= 1'b0;
      else if (active_reg)
         cnt_reg <= cnt_reg + 5'h01;
   end

endmodule // sasq_conv_timer

/* core/sasq_axil_slave.v */
// axi4-lite slave front end: channel handshakes and simple register strobes
`include "sasq_consts.vh"
module sasq_axil_slave (
   // clock and reset
   input  wire        clk,
   input  wire        nrst,
   // write address channel
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // write data channel
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // write response channel
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   // read address channel
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // read data channel
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   // register side
   output wire        wr_en,
   output wire [7:0]  wr_addr,
   output wire [31:0] wr_data,
   output wire [3:0]  wr_strb,
   input  wire        wr_ok,
   output wire [7:0]  rd_addr,
   input  wire [31:0] rd_data,
   input  wire        rd_ok
);

   reg        aw_held_reg;
   reg        w_held_reg;
   reg [7:0]  awaddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0]  wstrb_reg;
   reg        bvalid_reg;
   reg [1:0]  bresp_reg;
   reg        rvalid_reg;
   reg [1:0]  rresp_reg;
   reg [31:0] rdata_reg;

   assign s_axi_awready = ~aw_held_reg;
   assign s_axi_wready  = ~w_held_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = rdata_reg;
   assign wr_en         = aw_held_reg & w_held_reg & ~bvalid_reg;
   assign wr_addr       = awaddr_reg;
   assign wr_data       = wdata_reg;
   assign wr_strb       = wstrb_reg;
   assign rd_addr       = s_axi_araddr;

   // write: address and data are caught in either order, then one strobe
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `SASQ_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && !aw_held_reg)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held_reg)
         begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         if (wr_en)
         begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_ok ? `SASQ_RESP_OKAY : `SASQ_RESP_SLVERR;
         end
         else if (bvalid_reg && s_axi_bready)
            bvalid_reg <= 1'b0;
      end
   end

   // read: data is sampled at the address handshake
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rvalid_reg <= 1'b0;
         rresp_reg  <= `SASQ_RESP_OKAY;
         rdata_reg  <= 32'h0000_0000;
      end
      else if (s_axi_arvalid && !rvalid_reg)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= rd_ok ? `SASQ_RESP_OKAY : `SASQ_RESP_SLVERR;
         rdata_reg  <= rd_ok ? rd_data : 32'h0000_0000;
      end
      else if (rvalid_reg && s_axi_rready)
         rvalid_reg <= 1'b0;
   end

endmodule // sasq_axil_slave

/* core/sasq_top.v */
// scan sequencer for a 10-bit successive-approximation converter channel
`include "sasq_consts.vh"
module sasq_top (
   // shared timer clock and reset
   input  wire        sys_clk,
   input  wire        nrst,
   // axi4-lite write address channel
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // axi4-lite write data channel
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // axi4-lite write response channel
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read address channel
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // axi4-lite read data channel
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   // trigger sources
   input  wire        tmr_underflow,
   input  wire        ext_trigger_pin_n,
   // analog core
   output wire        adc_sample,
   output wire        adc_convert,
   output wire [2:0]  adc_input_sel,
   input  wire [9:0]  adc_result_data,
   // interrupt request
   output wire        irq
);

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_SYNC = 3'b010;
   localparam [2:0] ST_RUN  = 3'b100;
   localparam [2:0] IDX_MAX = 3'h7;

   // control and configuration
   reg        block_enable_reg;
   reg        trigger_accept_enable_reg;
   reg [2:0]  first_input_select_reg;
   reg [2:0]  last_input_select_reg;
   reg        result_alignment_select_reg;
   reg        repeat_scan_select_reg;
   reg [1:0]  trigger_source_select_reg;
   reg [2:0]  sample_cycle_count_reg;
   reg [15:0] inte_reg;
   // status
   reg [15:0] intf_reg;
   reg [15:0] intf_next;
   reg [2:0]  st_reg;
   reg [2:0]  st_next;
   reg [2:0]  current_input_index_reg;
   reg [2:0]  idx_next;
   reg        stop_req_reg;
   reg        stop_next;
   reg [1:0]  stop_hold_reg;
   reg [9:0]  res_mem [0:7];
   // pin synchroniser and edge detect
   reg        ext_s1_reg;
   reg        ext_s2_reg;
   reg        ext_s3_reg;
   // bus decode
   reg        ctl_wr;
   reg        trg_wr;
   reg        intf_wr;
   reg        inte_wr;
   reg        wr_ok;
   reg        rd_ok;
   reg [31:0] rd_data;
   reg        tmr_start;
   integer    i;

   wire        wr_en;
   wire [7:0]  wr_addr;
   wire [31:0] wr_data;
   wire [3:0]  wr_strb;
   wire [7:0]  rd_addr;
   wire        tmr_done;
   wire        busy;
   wire        conversion_active_status;
   wire [15:0] ctl_rd;
   wire [15:0] trg_rd;
   wire [15:0] ctl_new;
   wire [15:0] trg_new;
   wire [15:0] inte_new;
   wire [15:0] clr_mask;
   wire [7:0]  done_vec;
   wire [7:0]  ovr_vec;
   wire        ext_fall;
   wire        sw_go;
   wire        sw_stop;
   wire        hw_trig;
   wire        accept;
   wire        at_last;

   // byte-lane mask for the low half-word
   function [15:0] lane_mask;
      input [1:0] strb;
      begin
         lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
      end
   endfunction

   // merge written lanes into an old value
   function [15:0] lane_merge;
      input [15:0] old;
      input [15:0] data;
      input [1:0]  strb;
      begin
         lane_merge = (old & ~lane_mask(strb)) | (data & lane_mask(strb));
      end
   endfunction

   sasq_axil_slave u_bus (
      .clk           (sys_clk),
      .nrst          (nrst),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en         (wr_en),
      .wr_addr       (wr_addr),
      .wr_data       (wr_data),
      .wr_strb       (wr_strb),
      .wr_ok         (wr_ok),
      .rd_addr       (rd_addr),
      .rd_data       (rd_data),
      .rd_ok         (rd_ok)
   );

   // the timer runs on the same clock as the rest of the block
   sasq_conv_timer u_tmr (
      .clk        (sys_clk),
      .nrst       (nrst),
      .start      (tmr_start),
      .smp_code   (sample_cycle_count_reg),
      .sampling   (adc_sample),
      .converting (adc_convert),
      .done       (tmr_done)
   );

   assign busy                     = ~st_reg[0];
   assign conversion_active_status = busy;
   assign adc_input_sel            = current_input_index_reg;
   assign ctl_rd = {1'b0, current_input_index_reg, 1'b0, conversion_active_status,
                    5'h00, trigger_accept_enable_reg, 2'h0, busy, block_enable_reg};
   assign trg_rd = {2'h0, last_input_select_reg, first_input_select_reg,
                    result_alignment_select_reg, repeat_scan_select_reg,
                    trigger_source_select_reg, 1'b0, sample_cycle_count_reg};
   assign ctl_new  = lane_merge(ctl_rd, wr_data[15:0], wr_strb[1:0]);
   assign trg_new  = lane_merge(trg_rd, wr_data[15:0], wr_strb[1:0]);
   assign inte_new = lane_merge(inte_reg, wr_data[15:0], wr_strb[1:0]);

   // write address decode
   always @*
   begin
      ctl_wr  = 1'b0;
      trg_wr  = 1'b0;
      intf_wr = 1'b0;
      inte_wr = 1'b0;
      wr_ok   = 1'b1;
      if (wr_addr == `SASQ_OFS_CTL)
         ctl_wr = wr_en;
      else if (wr_addr == `SASQ_OFS_TRG)
         trg_wr = wr_en;
      else if (wr_addr == `SASQ_OFS_INTF)
         intf_wr = wr_en;
      else if (wr_addr == `SASQ_OFS_INTE)
         inte_wr = wr_en;
      else if ((wr_addr >= `SASQ_OFS_RES0) && (wr_addr <= `SASQ_OFS_RES7)
               && (wr_addr[1:0] == 2'b00))
         wr_ok = 1'b1;
      else
         wr_ok = 1'b0;
   end

   // read address decode; results re-align at once when alignment changes
   always @*
   begin
      rd_ok   = 1'b1;
      rd_data = 32'h0000_0000;
      if (rd_addr == `SASQ_OFS_CTL)
         rd_data = {16'h0000, ctl_rd};
      else if (rd_addr == `SASQ_OFS_TRG)
         rd_data = {16'h0000, trg_rd};
      else if (rd_addr == `SASQ_OFS_INTF)
         rd_data = {16'h0000, intf_reg};
      else if (rd_addr == `SASQ_OFS_INTE)
         rd_data = {16'h0000, inte_reg};
      else if ((rd_addr >= `SASQ_OFS_RES0) && (rd_addr <= `SASQ_OFS_RES7)
               && (rd_addr[1:0] == 2'b00))
      begin
         if (result_alignment_select_reg)
            rd_data = {16'h0000, res_mem[rd_addr[4:2]], 6'h00};
         else
            rd_data = {16'h0000, 6'h00, res_mem[rd_addr[4:2]]};
      end
      else
         rd_ok = 1'b0;
   end

   // trigger sources
   assign ext_fall = ext_s3_reg & ~ext_s2_reg;
   assign sw_go    = ctl_wr & ctl_new[`SASQ_CTL_SWST] & ctl_new[`SASQ_CTL_TRIGGER_ACCEPT_ENABLE]
                     & ctl_new[`SASQ_CTL_EN]
                     & (trigger_source_select_reg == `SASQ_SRC_SW);
   assign hw_trig  = trigger_accept_enable_reg & block_enable_reg
                     & (((trigger_source_select_reg == `SASQ_SRC_TMR) & tmr_underflow)
                     | ((trigger_source_select_reg == `SASQ_SRC_EXT) & ext_fall));
   assign accept   = (sw_go | hw_trig) & st_reg[0];

   // a zero written to the start bit is ignored briefly after a one
   assign sw_stop  = busy & ctl_wr & ((~ctl_new[`SASQ_CTL_SWST] & (stop_hold_reg == 2'h0))
                     | ~ctl_new[`SASQ_CTL_EN]);
   assign at_last  = current_input_index_reg >= last_input_select_reg;

   // sequence control
   always @*
   begin
      st_next   = st_reg;
      idx_next  = current_input_index_reg;
      stop_next = stop_req_reg | sw_stop;
      tmr_start = 1'b0;
      case (st_reg)
         ST_IDLE:
         begin
            stop_next = 1'b0;
            if (accept)
            begin
               st_next  = ST_SYNC;
               idx_next = first_input_select_reg;
            end
         end
         ST_SYNC:
         begin
            tmr_start = 1'b1;
            st_next   = ST_RUN;
         end
         ST_RUN:
         begin
            if (tmr_done)
            begin
               if (stop_next || (at_last && !repeat_scan_select_reg))
               begin
                  st_next = ST_IDLE;
                  if (current_input_index_reg == IDX_MAX)
                     idx_next = 3'h0;
               end
               else
               begin
                  tmr_start = 1'b1;
                  if (at_last)
                     idx_next = first_input_select_reg;
                  else
                     idx_next = current_input_index_reg + 3'h1;
               end
            end
         end
         default:
            st_next = ST_IDLE;
      endcase
   end

   // per-input events; a new event wins over a same-cycle clear
   assign done_vec = tmr_done ? (8'h01 << current_input_index_reg) : 8'h00;
   assign ovr_vec  = done_vec & intf_reg[7:0];
   assign clr_mask = intf_wr ? (wr_data[15:0] & lane_mask(wr_strb[1:0])) : 16'h0000;

   always @*
   begin
      intf_next = (intf_reg & ~clr_mask) | {ovr_vec, done_vec};
   end

   assign irq = |(intf_reg & inte_reg);

   // state, status and result storage
   always @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_reg                  <= ST_IDLE;
         current_input_index_reg <= 3'h0;
         stop_req_reg            <= 1'b0;
         stop_hold_reg           <= 2'h0;
         intf_reg                <= 16'h0000;
         for (i = 0; i < 8; i = i + 1)
            res_mem[i] <= 10'h000;
      end
      else
      begin
         st_reg                  <= st_next;
         current_input_index_reg <= idx_next;
         stop_req_reg            <= stop_next;
         intf_reg                <= intf_next;
         if (ctl_wr && ctl_new[`SASQ_CTL_SWST] && (wr_strb[0]))
            stop_hold_reg <= `SASQ_STOP_HOLD;
         else if (stop_hold_reg != 2'h0)
            stop_hold_reg <= stop_hold_reg - 2'h1;
         if (tmr_done)
            res_mem[current_input_index_reg] <= adc_result_data;
      end
   end

   // software-written configuration; select register is frozen while busy
   always @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         block_enable_reg            <= 1'b0;
         trigger_accept_enable_reg   <= 1'b0;
         first_input_select_reg      <= 3'h0;
         last_input_select_reg       <= 3'h0;
         result_alignment_select_reg <= 1'b0;
         repeat_scan_select_reg      <= 1'b0;
         trigger_source_select_reg   <= `SASQ_SRC_SW;
         sample_cycle_count_reg      <= `SASQ_SMP_RST;
         inte_reg                    <= 16'h0000;
      end
      else
      begin
         if (ctl_wr)
         begin
            block_enable_reg          <= ctl_new[`SASQ_CTL_EN];
            trigger_accept_enable_reg <= ctl_new[`SASQ_CTL_TRIGGER_ACCEPT_ENABLE];
         end
         if (trg_wr && !busy)
         begin
            last_input_select_reg       <= trg_new[`SASQ_TRG_LAST_LSB +: 3];
            first_input_select_reg      <= trg_new[`SASQ_TRG_FIRST_LSB +: 3];
            result_alignment_select_reg <= trg_new[`SASQ_TRG_ALIGN];
            repeat_scan_select_reg      <= trg_new[`SASQ_TRG_REP];
            trigger_source_select_reg   <= trg_new[`SASQ_TRG_SRC_LSB +: 2];
            sample_cycle_count_reg      <= trg_new[`SASQ_TRG_SMP_LSB +: 3];
         end
         if (inte_wr)
            inte_reg <= inte_new;
      end
   end

   // external trigger pin: two-stage synchroniser plus edge history
   always @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ext_s1_reg <= 1'b1;
         ext_s2_reg <= 1'b1;
         ext_s3_reg <= 1'b1;
      end
      else
      begin
         ext_s1_reg <= ext_trigger_pin_n;
         ext_s2_reg <= ext_s1_reg;
         ext_s3_reg <= ext_s2_reg;
      end
   end

endmodule // sasq_top

/* testbench/sasq_top_properties.sv */
// port checker for the scan sequencer, bound into the top module
module sasq_props (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        nrst,
   // bus
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // analog core
   input wire logic        adc_sample,
   input wire logic        adc_convert,
   input wire logic [2:0]  adc_input_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before taken");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before taken");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   AST_SMP_MIN: assert property ($rose(adc_sample) |-> adc_sample[*4])
      else $error("sampling shorter than four cycles");
   AST_SMP_MAX: assert property ($rose(adc_sample) |-> ##[4:11] $fell(adc_sample))
      else $error("sampling longer than eleven cycles");
   AST_SMP_TO_CNV: assert property ($fell(adc_sample) |-> adc_convert)
      else $error("conversion does not follow sampling");
   AST_CNV_LEN: assert property ($rose(adc_convert) |-> ##10 adc_convert ##1 !adc_convert)
      else $error("conversion phase not eleven cycles");
   AST_EXCL: assert property (!(adc_sample && adc_convert))
      else $error("sampling and conversion overlap");
   AST_SEL_STABLE: assert property (adc_convert |-> $stable(adc_input_sel))
      else $error("input index moved during conversion");
   COV_SCAN: cover property ($fell(adc_convert));
   COV_WR: cover property (s_axi_bvalid && s_axi_bready);
   COV_RD: cover property (s_axi_rvalid && s_axi_rready);
endmodule // sasq_props

bind sasq_top sasq_props props_u (.sys_clk(sys_clk), .nrst(nrst), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .adc_sample(adc_sample),
   .adc_convert(adc_convert), .adc_input_sel(adc_input_sel));

/* testbench/sasq_adc_model.sv */
// behavioural analog core: returns a code tied to the selected input
module sasq_adc_model (
   // analog core side
   input  wire logic       adc_convert,
   input  wire logic [2:0] adc_input_sel,
   output wire logic [9:0] adc_result_data
);
   timeunit 1ns;
   timeprecision 1ps;
   // outside conversion the line shows the inverse so early or late capture is caught
   assign adc_result_data = adc_convert ? {adc_input_sel, 4'hA, adc_input_sel}
                                        : ~{adc_input_sel, 4'hA, adc_input_sel};
endmodule // sasq_adc_model

/* testbench/sar_adc_scan_sequencer_tb_top.sv */
// self-checking bench for the scan sequencer
`include "sasq_consts.vh"
module sar_adc_scan_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  aw_addr = 8'h00;
   logic        aw_valid = 1'b0;
   logic [31:0] w_data = 32'h0000_0000;
   logic        w_valid = 1'b0;
   logic        b_ready = 1'b0;
   logic [7:0]  ar_addr = 8'h00;
   logic        ar_valid = 1'b0;
   logic        r_ready = 1'b0;
   logic        tmr_uf = 1'b0;
   logic        ext_n = 1'b1;
   logic        aw_ready, w_ready, b_valid, ar_ready, r_valid, smp, cnv, irq;
   logic [1:0]  b_resp, r_resp;
   logic [31:0] r_data;
   logic [2:0]  sel;
   logic [9:0]  res;
   int          n_fail = 0;
   int          num_checks = 0;

   always #5 sys_clk = ~sys_clk;

   sasq_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(aw_addr),
      .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready), .s_axi_wdata(w_data),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready), .s_axi_bresp(b_resp),
      .s_axi_bvalid(b_valid), .s_axi_bready(b_ready), .s_axi_araddr(ar_addr),
      .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready), .s_axi_rdata(r_data),
      .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid), .s_axi_rready(r_ready),
      .tmr_underflow(tmr_uf), .ext_trigger_pin_n(ext_n), .adc_sample(smp), .adc_convert(cnv),
      .adc_input_sel(sel), .adc_result_data(res), .irq(irq));
   sasq_adc_model adc_u (.adc_convert(cnv), .adc_input_sel(sel), .adc_result_data(res));

   task automatic report_and_stop;
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tmo;
      n_fail++;
      $display("BAD handshake expected done seen timeout");
      report_and_stop();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      tb = 1'b0;
      @(posedge sys_clk);
      aw_addr <= a;
      aw_valid <= 1'b1;
      w_data <= d;
      w_valid <= 1'b1;
      b_ready <= 1'b1;
      for (int n = 0; n < 50 && !tb; n++)
      begin
         @(negedge sys_clk);
         ta = aw_valid && aw_ready;
         tw = w_valid && w_ready;
         tb = b_valid;
         @(posedge sys_clk);
         if (ta) aw_valid <= 1'b0;
         if (tw) w_valid <= 1'b0;
         if (tb) b_ready <= 1'b0;
      end
      if (!tb) tmo();
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rp);
      logic ta, tr;
      tr = 1'b0;
      @(posedge sys_clk);
      ar_addr <= a;
      ar_valid <= 1'b1;
      r_ready <= 1'b1;
      for (int n = 0; n < 50 && !tr; n++)
      begin
         @(negedge sys_clk);
         ta = ar_valid && ar_ready;
         tr = r_valid;
         d = r_data;
         rp = r_resp;
         @(posedge sys_clk);
         if (ta) ar_valid <= 1'b0;
         if (tr) r_ready <= 1'b0;
      end
      if (!tr) tmo();
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  rp;
      rd(a, d, rp);
      chk(nm, e, d);
   endtask
   task automatic wait_idle;
      logic [31:0] d;
      logic [1:0]  rp;
      d = 32'h0000_0400;
      for (int n = 0; n < 100 && d[10] !== 1'b0; n++)
         rd(`SASQ_OFS_CTL, d, rp);
      if (d[10] !== 1'b0) tmo();
   endtask
   task automatic pulse_tmr;
      @(posedge sys_clk);
      tmr_uf <= 1'b1;
      @(posedge sys_clk);
      tmr_uf <= 1'b0;
   endtask
   function automatic logic [31:0] rv(input logic [2:0] m, input logic left);
      logic [9:0] r;
      r = {m, 4'hA, m};
      return left ? {16'h0000, r, 6'h00} : {22'h000000, r};
   endfunction

   task automatic t_reset;
      logic [31:0] d;
      logic [1:0]  rp;
      rchk("trg", `SASQ_OFS_TRG, 32'h0000_0005);
      rd(8'h10, d, rp);
      chk("resp", {30'h0, `SASQ_RESP_SLVERR}, {30'h0, rp});
      wr(8'h10, 32'h0000_0013);
      chk("bresp", {30'h0, `SASQ_RESP_SLVERR}, {30'h0, b_resp});
   endtask
   task automatic t_single;
      logic [31:0] d;
      logic [1:0]  rp;
      wr(`SASQ_OFS_TRG, 32'h0000_1900);
      chk("bresp", {30'h0, `SASQ_RESP_OKAY}, {30'h0, b_resp});
      wr(`SASQ_OFS_CTL, 32'h0000_0013);
      rd(`SASQ_OFS_CTL, d, rp);
      chk("busy", 32'h1, {31'h0, d[10]});
      wait_idle();
      rchk("done", `SASQ_OFS_INTF, 32'h0000_000E);
      for (int m = 0; m < 4; m++)
         rchk("res", 8'h20 + 8'(4 * m), m == 0 ? 32'h0 : rv(3'(m), 1'b0));
      rchk("ctl", `SASQ_OFS_CTL, 32'h0000_3011);
      wr(`SASQ_OFS_TRG, 32'h0000_1980);
      rchk("left", 8'h24, rv(3'h1, 1'b1));
   endtask
   task automatic t_overrun;
      wr(`SASQ_OFS_CTL, 32'h0000_0013);
      wait_idle();
      rchk("ovr", `SASQ_OFS_INTF, 32'h0000_0E0E);
      wr(`SASQ_OFS_INTE, 32'h0000_0200);
      chk("irq", 32'h1, {31'h0, irq});
      wr(`SASQ_OFS_INTF, 32'h0000_0200);
      wr(`SASQ_OFS_INTF, 32'h0000_0000);
      rchk("clr", `SASQ_OFS_INTF, 32'h0000_0C0E);
      chk("irq", 32'h0, {31'h0, irq});
      wr(`SASQ_OFS_INTF, 32'h0000_FFFF);
   endtask
   task automatic t_triggers;
      wr(`SASQ_OFS_TRG, 32'h0000_2D17);
      wr(`SASQ_OFS_CTL, 32'h0000_0011);
      pulse_tmr();
      repeat (6) @(posedge sys_clk);
      pulse_tmr();
      wait_idle();
      rchk("tmr", `SASQ_OFS_INTF, 32'h0000_0020);
      wr(`SASQ_OFS_TRG, 32'h0000_3630);
      @(posedge sys_clk);
      ext_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      ext_n <= 1'b1;
      wait_idle();
      rchk("ext", `SASQ_OFS_INTF, 32'h0000_0060);
      wr(`SASQ_OFS_TRG, 32'h0000_3600);
      wr(`SASQ_OFS_CTL, 32'h0000_0003);
      wr(`SASQ_OFS_TRG, 32'h0000_3620);
      wr(`SASQ_OFS_CTL, 32'h0000_0013);
      pulse_tmr();
      wait_idle();
      rchk("rsvd", `SASQ_OFS_INTF, 32'h0000_0060);
   endtask
   task automatic t_repeat;
      wr(`SASQ_OFS_INTF, 32'h0000_FFFF);
      wr(`SASQ_OFS_TRG, 32'h0000_0040);
      wr(`SASQ_OFS_CTL, 32'h0000_0013);
      repeat (40) @(posedge sys_clk);
      wr(`SASQ_OFS_CTL, 32'h0000_0011);
      wait_idle();
      rchk("rep", `SASQ_OFS_INTF, 32'h0000_0101);
      rchk("res0", 8'h20, rv(3'h0, 1'b0));
   endtask

   initial
   begin
      repeat (12) @(posedge sys_clk);
      nrst <= 1'b1;
      t_reset();
      t_single();
      t_overrun();
      t_triggers();
      t_repeat();
      report_and_stop();
   end
endmodule // sar_adc_scan_sequencer_tb_top
